//--- pkg/spp_pkg.sv
/*
 Shared constants and carriers for the servo positioning profile block.
 Assumes a 25 MHz clock and a 32-bit AXI4-Lite register bus.
*/
package spp_pkg;

  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] SPP_OFS_CTRL      = 8'h00;
  localparam logic [7:0] SPP_OFS_GEAR_NUM  = 8'h04;
  localparam logic [7:0] SPP_OFS_GEAR_DEN  = 8'h08;
  localparam logic [7:0] SPP_OFS_SCURVE    = 8'h0c;
  localparam logic [7:0] SPP_OFS_STOPSEL   = 8'h10;
  localparam logic [7:0] SPP_OFS_COARSE    = 8'h14;
  localparam logic [7:0] SPP_OFS_LIM_POS   = 8'h18;
  localparam logic [7:0] SPP_OFS_LIM_NEG   = 8'h1c;
  localparam logic [7:0] SPP_OFS_CMD       = 8'h20;
  localparam logic [7:0] SPP_OFS_STATUS    = 8'h24;
  localparam logic [7:0] SPP_OFS_IRQ_STAT  = 8'h28;
  localparam logic [7:0] SPP_OFS_IRQ_MASK  = 8'h2c;
  localparam logic [7:0] SPP_OFS_POSITION  = 8'h30;
  localparam logic [7:0] SPP_OFS_ALARM     = 8'h34;

  // ----------------------------------------
  // Control bits and reset values
  // ----------------------------------------
  localparam int         SPP_CTRL_START    = 0;
  localparam int         SPP_CTRL_HOMING   = 1;
  localparam int         SPP_CTRL_RESTART  = 2;
  localparam logic [15:0] SPP_GEAR_NUM_RST = 16'h0001;
  localparam logic [15:0] SPP_GEAR_DEN_RST = 16'h0001;
  localparam logic [7:0]  SPP_ALARM_PARAM  = 8'h25;
  localparam logic [1:0]  SPP_RESP_OKAY    = 2'b00;
  localparam logic [1:0]  SPP_RESP_SLVERR  = 2'b10;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int SPP_CLK_HZ        = 25_000_000;
  localparam int SPP_MS_CYCLES     = SPP_CLK_HZ / 1000;
  localparam int SPP_SCURVE_MAX_MS = 100;
  localparam int SPP_IRQ_W         = 4;

  typedef enum logic [3:0] {
    SPP_IDLE  = 4'b0001,
    SPP_MOVE  = 4'b0010,
    SPP_SETTL = 4'b0100,
    SPP_HALT  = 4'b1000
  } spp_state_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] incr;
  } spp_step_t;

endpackage

//--- design/spp_servo_positioning.sv
/*
 Servo positioning profile: electronic gear, S-curve settle delay, limit stop,
 coarse position flag and software limits, behind an AXI4-Lite slave.
 Assumes one 25 MHz clock, synchronous active-low reset as power-on.
*/
`timescale 1ns/1ps
module spp_servo_positioning
  import spp_pkg::*;
#(
  parameter int SCURVE_MS_CYCLES = SPP_MS_CYCLES
) (
  input  wire logic        aclk,          // System clock
  input  wire logic        aresetn,       // Synchronous reset, active low
  input  wire logic [7:0]  s_axi_awaddr,  // Write address
  input  wire logic        s_axi_awvalid, // Write address valid
  output logic             s_axi_awready, // Write address ready
  input  wire logic [31:0] s_axi_wdata,   // Write data
  input  wire logic [3:0]  s_axi_wstrb,   // Write strobes
  input  wire logic        s_axi_wvalid,  // Write data valid
  output logic             s_axi_wready,  // Write data ready
  output logic [1:0]       s_axi_bresp,   // Write response
  output logic             s_axi_bvalid,  // Write response valid
  input  wire logic        s_axi_bready,  // Write response ready
  input  wire logic [7:0]  s_axi_araddr,  // Read address
  input  wire logic        s_axi_arvalid, // Read address valid
  output logic             s_axi_arready, // Read address ready
  output logic [31:0]      s_axi_rdata,   // Read data
  output logic [1:0]       s_axi_rresp,   // Read response
  output logic             s_axi_rvalid,  // Read data valid
  input  wire logic        s_axi_rready,  // Read data ready
  input  wire logic        limit_pos_hit, // Positive stroke-end switch
  input  wire logic        limit_neg_hit, // Negative stroke-end switch
  output spp_step_t        pos_step,      // Scaled increment to position loop
  output logic             servo_lock,    // Motor held servo-locked
  output logic             motion_complete_flag, // Motion finished
  output logic             coarse_position_flag, // Near target
  output logic             irq            // Interrupt, level
);

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [15:0] gear_num_reg, gear_den_reg, gear_num_act_reg, gear_den_act_reg;
  logic [6:0]  scurve_reg;
  logic        stopsel_reg, stopsel_act_reg, homing_reg;
  logic [15:0] coarse_reg;
  logic signed [31:0] lim_pos_reg, lim_neg_reg;
  logic signed [31:0] cmd_reg, position_reg, remain_reg, droop_reg;
  logic [31:0] rem_acc_reg;
  logic [SPP_IRQ_W-1:0] irq_stat_reg, irq_mask_reg;
  logic        alarm_reg;
  spp_state_t  state_reg;
  logic [31:0] settle_cnt_reg;
  logic        aw_hold_reg, w_hold_reg;
  logic [7:0]  awaddr_reg;
  logic [31:0] wdata_reg;

  // Write channel: address and data may arrive in either order
  wire        aw_take  = s_axi_awvalid && s_axi_awready;
  wire        w_take   = s_axi_wvalid && s_axi_wready;
  wire        aw_have  = aw_hold_reg || aw_take;
  wire        w_have   = w_hold_reg || w_take;
  wire [7:0]  wr_addr  = aw_hold_reg ? awaddr_reg : s_axi_awaddr;
  wire [31:0] wr_data  = w_hold_reg ? wdata_reg : s_axi_wdata;
  wire        wr_fire  = aw_have && w_have && !s_axi_bvalid;
  wire        wr_ok    = wr_addr[7:2] <= SPP_OFS_ALARM[7:2] && wr_addr[1:0] == 2'b00;
  assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  wire wr_ctrl   = wr_fire && wr_addr == SPP_OFS_CTRL;
  wire wr_cmd    = wr_fire && wr_addr == SPP_OFS_CMD;
  wire wr_istat  = wr_fire && wr_addr == SPP_OFS_IRQ_STAT;
  wire start_cmd = wr_ctrl && wr_data[SPP_CTRL_START];
  // Restart stands in for the power cycle of the real amplifier
  wire restart   = wr_ctrl && wr_data[SPP_CTRL_RESTART];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg  <= 1'b0;
      w_hold_reg   <= 1'b0;
      awaddr_reg   <= 8'h00;
      wdata_reg    <= 32'h0000_0000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= SPP_RESP_OKAY;
    end else begin
      if (aw_take) awaddr_reg <= s_axi_awaddr;
      if (w_take) wdata_reg <= s_axi_wdata;
      aw_hold_reg <= aw_have && !wr_fire;
      w_hold_reg  <= w_have && !wr_fire;
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? SPP_RESP_OKAY : SPP_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Parameters accepted whenever written, incl. at link bring-up
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gear_num_reg <= SPP_GEAR_NUM_RST;
      gear_den_reg <= SPP_GEAR_DEN_RST;
      scurve_reg   <= 7'h00;
      stopsel_reg  <= 1'b0;
      homing_reg   <= 1'b0;
      coarse_reg   <= 16'h0000;
      lim_pos_reg  <= 32'h0000_0000;
      lim_neg_reg  <= 32'h0000_0000;
      irq_mask_reg <= '0;
    end else if (wr_fire) begin
      case (wr_addr)
        SPP_OFS_CTRL:     homing_reg   <= wr_data[SPP_CTRL_HOMING];
        SPP_OFS_GEAR_NUM: gear_num_reg <= wr_data[15:0];
        SPP_OFS_GEAR_DEN: gear_den_reg <= (wr_data[15:0] == 16'h0000) ? 16'h0001 : wr_data[15:0];
        SPP_OFS_SCURVE:   scurve_reg   <= (wr_data[6:0] > 7'(SPP_SCURVE_MAX_MS)) ?
                                          7'(SPP_SCURVE_MAX_MS) : wr_data[6:0];
        SPP_OFS_STOPSEL:  stopsel_reg  <= wr_data[0];
        SPP_OFS_COARSE:   coarse_reg   <= wr_data[15:0];
        SPP_OFS_LIM_POS:  lim_pos_reg  <= wr_data;
        SPP_OFS_LIM_NEG:  lim_neg_reg  <= wr_data;
        SPP_OFS_IRQ_MASK: irq_mask_reg <= wr_data[SPP_IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // Restart-required values copied to the working set only at restart
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gear_num_act_reg <= SPP_GEAR_NUM_RST;
      gear_den_act_reg <= SPP_GEAR_DEN_RST;
      stopsel_act_reg  <= 1'b0;
    end else if (restart) begin
      gear_num_act_reg <= gear_num_reg;
      gear_den_act_reg <= gear_den_reg;
      stopsel_act_reg  <= stopsel_reg;
    end
  end

  // ----------------------------------------
  // Software limits
  // ----------------------------------------
  wire lim_equal   = lim_pos_reg == lim_neg_reg;
  wire lim_bad     = lim_pos_reg < lim_neg_reg;
  wire sw_lim_on   = !homing_reg && !lim_equal && !lim_bad;
  wire sw_over     = sw_lim_on && (position_reg > lim_pos_reg || position_reg < lim_neg_reg);
  wire limit_event = limit_pos_hit || limit_neg_hit || sw_over;

  always_ff @(posedge aclk) begin
    if (!aresetn) alarm_reg <= 1'b0;
    else alarm_reg <= lim_bad;
  end

  // ----------------------------------------
  // Electronic gear with remainder carry
  // ----------------------------------------
  logic signed [31:0] step_dir;
  logic        [31:0] step_mag;
  wire  [47:0] gear_prod  = 48'(step_mag) * 48'(gear_num_act_reg);
  wire  [47:0] gear_sum   = gear_prod + 48'(rem_acc_reg);
  wire  [47:0] gear_quot  = gear_sum / 48'(gear_den_act_reg);
  wire  [47:0] gear_rem   = gear_sum % 48'(gear_den_act_reg);
  wire  move_step         = state_reg == SPP_MOVE && remain_reg != 0 && !limit_event;
  wire  drain_step        = state_reg == SPP_HALT && droop_reg != 0;
  wire  remain_neg        = remain_reg < 0;
  wire  [31:0] remain_abs = remain_neg ? 32'(-remain_reg) : 32'(remain_reg);

  // Linear ramp: one command count per cycle; S-curve only lengthens settle
  always_comb begin
    step_mag = move_step ? 32'h0000_0001 : 32'h0000_0000;
    step_dir = remain_neg ? -32'sd1 : 32'sd1;
  end

  wire [31:0] settle_len = 32'(scurve_reg) * 32'(SCURVE_MS_CYCLES);
  wire signed [31:0] scaled_out = remain_neg ? -32'(gear_quot) : 32'(gear_quot);

  // ----------------------------------------
  // Motion sequencer
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg      <= SPP_IDLE;
      cmd_reg        <= 32'h0000_0000;
      remain_reg     <= 32'h0000_0000;
      position_reg   <= 32'h0000_0000;
      droop_reg      <= 32'h0000_0000;
      rem_acc_reg    <= 32'h0000_0000;
      settle_cnt_reg <= 32'h0000_0000;
      pos_step       <= '0;
    end else begin
      pos_step <= '0;
      if (wr_cmd) cmd_reg <= wr_data;
      case (state_reg)
        SPP_IDLE: begin
          if (start_cmd && !alarm_reg) begin
            remain_reg <= cmd_reg;
            state_reg  <= SPP_MOVE;
          end
        end
        SPP_MOVE: begin
          if (limit_event) begin
            remain_reg <= 32'h0000_0000;
            if (!stopsel_act_reg) droop_reg <= 32'h0000_0000;
            state_reg <= SPP_HALT;
          end else if (remain_reg == 0) begin
            settle_cnt_reg <= settle_len;
            state_reg      <= SPP_SETTL;
          end else begin
            remain_reg   <= remain_reg - step_dir;
            position_reg <= position_reg + step_dir;
            rem_acc_reg  <= gear_rem[31:0];
            droop_reg    <= droop_reg + scaled_out;
            pos_step     <= '{valid: gear_quot != 0, incr: scaled_out};
          end
        end
        SPP_SETTL: begin
          if (settle_cnt_reg == 0) state_reg <= SPP_IDLE;
          else settle_cnt_reg <= settle_cnt_reg - 32'h0000_0001;
        end
        SPP_HALT: begin
          if (drain_step) begin
            droop_reg <= droop_reg - (droop_reg < 0 ? -32'sd1 : 32'sd1);
            pos_step  <= '{valid: 1'b1, incr: (droop_reg < 0 ? -32'sd1 : 32'sd1)};
          end else if (start_cmd && !limit_event) begin
            state_reg <= SPP_IDLE;
          end
        end
        default: state_reg <= SPP_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      motion_complete_flag <= 1'b1;
      coarse_position_flag <= 1'b0;
    end else begin
      motion_complete_flag <= state_reg == SPP_IDLE && !start_cmd;
      coarse_position_flag <= state_reg != SPP_IDLE && state_reg != SPP_HALT &&
                              remain_abs <= 32'(coarse_reg);
    end
  end
  assign servo_lock = state_reg == SPP_HALT;

  // ----------------------------------------
  // Interrupts: 0 complete, 1 coarse, 2 limit stop, 3 alarm
  // ----------------------------------------
  logic done_d_reg, coarse_d_reg, halt_d_reg, alarm_d_reg;
  wire [SPP_IRQ_W-1:0] irq_ev = {alarm_reg && !alarm_d_reg, servo_lock && !halt_d_reg,
                                 coarse_position_flag && !coarse_d_reg,
                                 motion_complete_flag && !done_d_reg};
  wire [SPP_IRQ_W-1:0] irq_clr = wr_istat ? wr_data[SPP_IRQ_W-1:0] : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_reg <= '0;
      done_d_reg   <= 1'b1;
      coarse_d_reg <= 1'b0;
      halt_d_reg   <= 1'b0;
      alarm_d_reg  <= 1'b0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_ev;
      done_d_reg   <= motion_complete_flag;
      coarse_d_reg <= coarse_position_flag;
      halt_d_reg   <= servo_lock;
      alarm_d_reg  <= alarm_reg;
    end
  end
  assign irq = |(irq_stat_reg & irq_mask_reg);

  // ----------------------------------------
  // Read channel
  // ----------------------------------------
  logic [31:0] rd_mux;
  always_comb begin
    case (s_axi_araddr)
      SPP_OFS_CTRL:     rd_mux = {30'h0, homing_reg, 1'b0};
      SPP_OFS_GEAR_NUM: rd_mux = {16'h0, gear_num_reg};
      SPP_OFS_GEAR_DEN: rd_mux = {16'h0, gear_den_reg};
      SPP_OFS_SCURVE:   rd_mux = {25'h0, scurve_reg};
      SPP_OFS_STOPSEL:  rd_mux = {31'h0, stopsel_reg};
      SPP_OFS_COARSE:   rd_mux = {16'h0, coarse_reg};
      SPP_OFS_LIM_POS:  rd_mux = lim_pos_reg;
      SPP_OFS_LIM_NEG:  rd_mux = lim_neg_reg;
      SPP_OFS_CMD:      rd_mux = cmd_reg;
      SPP_OFS_STATUS:   rd_mux = {26'h0, sw_lim_on, servo_lock, coarse_position_flag,
                                  motion_complete_flag, state_reg[1], alarm_reg};
      SPP_OFS_IRQ_STAT: rd_mux = {28'h0, irq_stat_reg};
      SPP_OFS_IRQ_MASK: rd_mux = {28'h0, irq_mask_reg};
      SPP_OFS_POSITION: rd_mux = position_reg;
      SPP_OFS_ALARM:    rd_mux = {24'h0, alarm_reg ? SPP_ALARM_PARAM : 8'h00};
      default:          rd_mux = 32'h0000_0000;
    endcase
  end
  wire rd_ok = s_axi_araddr[7:2] <= SPP_OFS_ALARM[7:2] && s_axi_araddr[1:0] == 2'b00;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= SPP_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_ok ? SPP_RESP_OKAY : SPP_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

//--- tb/spp_properties.sv
/*
 Port-level checks for the servo positioning block.
 Assumes a bind onto spp_servo_positioning, one clock, sync active-low reset.
*/
`timescale 1ns/1ps
module spp_properties
  import spp_pkg::*;
#(
  parameter int SCURVE_MS_CYCLES = SPP_MS_CYCLES
) (
  input wire logic        aclk,                 // Clock
  input wire logic        aresetn,              // Reset, active low
  input wire logic        s_axi_awvalid,        // Write address valid
  input wire logic        s_axi_wvalid,         // Write data valid
  input wire logic [1:0]  s_axi_bresp,          // Write response
  input wire logic        s_axi_bvalid,         // Write response valid
  input wire logic        s_axi_bready,         // Write response ready
  input wire logic        s_axi_arvalid,        // Read address valid
  input wire logic [31:0] s_axi_rdata,          // Read data
  input wire logic        s_axi_rvalid,         // Read data valid
  input wire logic        s_axi_rready,         // Read data ready
  input wire logic        limit_pos_hit,        // Positive switch
  input wire spp_step_t   pos_step,             // Scaled increment
  input wire logic        servo_lock,           // Servo locked
  input wire logic        motion_complete_flag  // Motion finished
);
  // ----------------------------------------
  // Port relations
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped early");
  bvalid_cause_a: assert property ($rose(s_axi_bvalid) |->
    $past(s_axi_awvalid) || $past(s_axi_wvalid)) else $error("response without request");
  rvalid_cause_a: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid))
    else $error("read data without request");
  step_nonzero_a: assert property (
    pos_step.valid |-> pos_step.incr != 32'h0) else $error("empty step issued");
  idle_no_step_a: assert property (
    motion_complete_flag && $past(motion_complete_flag) |-> !pos_step.valid)
    else $error("step while idle");
  lock_not_done_a: assert property (
    servo_lock && $past(servo_lock) |-> !motion_complete_flag)
    else $error("complete while locked");
  limit_halt_a: assert property (
    pos_step.valid && limit_pos_hit |-> ##[0:3] servo_lock) else $error("no halt on switch");
  start_cause_a: assert property ($fell(motion_complete_flag) |->
    $rose(s_axi_bvalid)) else $error("motion without start write");
endmodule

bind spp_servo_positioning spp_properties #(.SCURVE_MS_CYCLES(SCURVE_MS_CYCLES)) chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .limit_pos_hit(limit_pos_hit),
  .pos_step(pos_step), .servo_lock(servo_lock), .motion_complete_flag(motion_complete_flag));

//--- tb/spp_loop_model.sv
/*
 Position loop model: sums the scaled steps and closes a stroke-end switch.
 Assumes the block's clock and reset.
*/
`timescale 1ns/1ps
module spp_loop_model
  import spp_pkg::*;
(
  input  wire logic        aclk,          // Clock
  input  wire logic        aresetn,       // Reset, active low
  input  wire spp_step_t   pos_step,      // Step from the block
  input  wire logic [31:0] stroke,        // Switch position
  input  wire logic        stroke_en,     // Switch mounted
  output logic [31:0]      total,         // Accumulated position
  output logic [31:0]      steps,         // Steps received
  output logic             limit_pos_hit  // Positive stroke-end switch
);
  // Switch stays closed while the axle sits past it
  assign limit_pos_hit = stroke_en && ($signed(total) >= $signed(stroke));
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      total <= 32'h0;
      steps <= 32'h0;
    end else if (pos_step.valid) begin
      total <= total + pos_step.incr;
      steps <= steps + 32'h1;
    end
  end
endmodule

//--- tb/tb_servo_positioning_profile.sv
/*
 Self-checking bench for the servo positioning block.
 Assumes the bound checker and the loop model; shortened millisecond count.
*/
`timescale 1ns/1ps
module tb_servo_positioning_profile;
  import spp_pkg::*;
  localparam int MSC = 4;
  logic        aclk = 1'b0, aresetn = 1'b0, stroke_en = 1'b0, neg_hit = 1'b0;
  logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0, stroke = 32'h0, rd, total, steps;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, lim, lock, done, coarse, irq;
  logic [1:0]  bresp, rresp, rsp;
  logic [31:0] rdata;
  spp_step_t   pos_step;
  int          failures = 0, comparisons = 0;
  always #20 aclk = ~aclk;
  spp_servo_positioning #(.SCURVE_MS_CYCLES(MSC)) uut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .limit_pos_hit(lim), .limit_neg_hit(neg_hit), .pos_step(pos_step), .servo_lock(lock),
    .motion_complete_flag(done), .coarse_position_flag(coarse), .irq(irq));
  spp_loop_model loop_i (.aclk(aclk), .aresetn(aresetn), .pos_step(pos_step),
    .stroke(stroke), .stroke_en(stroke_en), .total(total), .steps(steps), .limit_pos_hit(lim));
  // ----------------------------------------
  // Bus cycles and helpers
  // ----------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    rsp = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_read(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask
  task automatic start_move(input logic [31:0] cmd);
    axi_write(SPP_OFS_CMD, cmd);
    axi_write(SPP_OFS_CTRL, 32'h1);
  endtask
  task automatic wait_done(output int n);
    n = 0;
    while (done !== 1'b0 && n < 20) begin @(posedge aclk); n++; end
    while (done !== 1'b1 && n < 3000) begin @(posedge aclk); n++; end
    check({31'h0, done}, 32'h1);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_softlimit();
    int n = 0;
    axi_read(SPP_OFS_GEAR_NUM);
    check(rd, {16'h0, SPP_GEAR_NUM_RST});
    axi_read(8'h38);
    check({30'h0, rsp}, {30'h0, SPP_RESP_SLVERR});
    check(rd, 32'h0);
    axi_write(SPP_OFS_LIM_POS, 32'h3);
    start_move(32'd10);
    while (lock !== 1'b1 && n < 200) begin @(posedge aclk); n++; end
    check({31'h0, lock}, 32'h1);
    axi_write(SPP_OFS_CTRL, 32'h2);
    axi_write(SPP_OFS_CTRL, 32'h3);
    wait_done(n);
    axi_write(SPP_OFS_CMD, 32'd6);
    axi_write(SPP_OFS_CTRL, 32'h3);
    wait_done(n);
    check({31'h0, done & ~lock}, 32'h1);
    axi_write(SPP_OFS_LIM_POS, 32'h0);
    start_move(32'd6);
    wait_done(n);
    check({31'h0, done & ~lock}, 32'h1);
  endtask
  task automatic t_alarm();
    axi_write(SPP_OFS_IRQ_MASK, 32'h8);
    axi_write(SPP_OFS_LIM_POS, 32'h1);
    axi_write(SPP_OFS_LIM_NEG, 32'h4);
    axi_read(SPP_OFS_ALARM);
    check(rd, {24'h0, SPP_ALARM_PARAM});
    check({31'h0, irq}, 32'h1);
    axi_write(SPP_OFS_LIM_NEG, 32'h1);
    axi_write(SPP_OFS_IRQ_MASK, 32'h0);
    check({31'h0, irq}, 32'h0);
    axi_write(SPP_OFS_IRQ_MASK, 32'h8);
    check({31'h0, irq}, 32'h1);
    axi_write(SPP_OFS_IRQ_STAT, 32'h8);
    check({31'h0, irq}, 32'h0);
    axi_write(SPP_OFS_IRQ_MASK, 32'h0);
  endtask
  task automatic t_gear();
    int n;
    logic [31:0] s0, c0;
    axi_write(SPP_OFS_GEAR_NUM, 32'd3);
    axi_write(SPP_OFS_GEAR_DEN, 32'd2);
    s0 = total;
    start_move(32'd2);
    wait_done(n);
    check(total - s0, 32'd2);
    axi_write(SPP_OFS_CTRL, 32'h4);
    s0 = total;
    c0 = steps;
    start_move(32'd4);
    wait_done(n);
    check(total - s0, 32'd6);
    check(steps - c0, 32'd4);
  endtask
  task automatic t_scurve();
    int n0, n1;
    axi_write(SPP_OFS_SCURVE, 32'd0);
    start_move(32'd4);
    wait_done(n0);
    axi_write(SPP_OFS_SCURVE, 32'd2);
    start_move(32'd4);
    wait_done(n1);
    check(32'(n1 - n0), 32'(2 * MSC));
    axi_write(SPP_OFS_SCURVE, 32'd0);
  endtask
  task automatic t_neglimit();
    int n = 0;
    start_move(32'd20);
    neg_hit <= 1'b1;
    while (lock !== 1'b1 && n < 50) begin @(posedge aclk); n++; end
    check({31'h0, lock}, 32'h1);
    neg_hit <= 1'b0;
    axi_write(SPP_OFS_CTRL, 32'h1);
    wait_done(n);
  endtask
  task automatic t_stop(input logic [31:0] sel);
    int n = 0;
    logic [31:0] c0;
    axi_write(SPP_OFS_STOPSEL, sel);
    axi_write(SPP_OFS_CTRL, 32'h4);
    stroke <= total + 32'd5;
    stroke_en <= 1'b1;
    start_move(32'd20);
    while (lock !== 1'b1 && n < 200) begin @(posedge aclk); n++; end
    c0 = steps;
    repeat (30) @(posedge aclk);
    c0 = steps - c0;
    if (sel[0]) check({31'h0, c0 > 32'd2}, 32'h1);
    else check({31'h0, c0 <= 32'd1}, 32'h1);
    stroke_en <= 1'b0;
    axi_write(SPP_OFS_CTRL, 32'h1);
    wait_done(n);
  endtask
  task automatic t_coarse();
    int n = 0;
    logic [31:0] c0;
    axi_write(SPP_OFS_COARSE, 32'd3);
    c0 = steps;
    start_move(32'd10);
    while (coarse !== 1'b0 && n < 20) begin @(posedge aclk); n++; end
    while (coarse !== 1'b1 && n < 200) begin @(posedge aclk); n++; end
    c0 = steps - c0;
    check({31'h0, c0 >= 32'd6 && c0 <= 32'd8}, 32'h1);
    wait_done(n);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    axi_write(SPP_OFS_STOPSEL, 32'h0);
    t_softlimit();
    t_alarm();
    t_gear();
    t_scurve();
    t_neglimit();
    t_stop(32'h0);
    t_stop(32'h1);
    t_coarse();
    tally_and_finish();
  end
  initial begin
    #2_000_000;
    failures++;
    tally_and_finish();
  end
endmodule
